/* src/pabc_bus_regs.vh */
`ifndef PABC_BUS_REGS_VH
`define PABC_BUS_REGS_VH
// ****************************************************************
// bus state codes
// ****************************************************************
`define PABC_ST_IDLE 3'h0
`define PABC_ST_HOLD 3'h1
`define PABC_ST_NP1 3'h2
`define PABC_ST_NP2 3'h3
`define PABC_ST_P1 3'h4
`define PABC_ST_P2A 3'h5
`define PABC_ST_P2I 3'h6
// ****************************************************************
// phase of the bus state, one double rate clock each
// ****************************************************************
`define PABC_PH_ONE 1'h0
`define PABC_PH_TWO 1'h1
// ****************************************************************
// pin input synchroniser
// ****************************************************************
`define PABC_SYNC_W 3
`define PABC_IN_READY 0
`define PABC_IN_NA 1
`define PABC_IN_HOLD 2
// reset value of the filtered pins: strobes negated, hold absent
`define PABC_IN_RST 3'h3
// ****************************************************************
// widths
// ****************************************************************
`define PABC_AW 23
`define PABC_DW 16
`endif

/* src/pabc_bus_cycles.v */
`timescale 1ns/100ps
`include "pabc_bus_regs.vh"
module pabc_bus_cycles (
  // clock and reset
  input wire clk_sys_in,
  input wire reset_n_in,
  // pins from the system
  input wire ready_n_in,
  input wire next_addr_request_n_in,
  input wire hold_request_in,
  input wire [`PABC_DW-1:0] data_in,
  // pins to the system
  output reg [`PABC_AW-1:0] addr_out,
  output reg upper_byte_enable_n_out,
  output reg lower_byte_enable_n_out,
  output reg write_read_out,
  output reg data_ctrl_out,
  output reg mem_io_out,
  output reg addr_valid_strobe_n_out,
  output reg hold_grant_out,
  output reg [`PABC_DW-1:0] data_out,
  output reg data_oe_out,
  // internal request side
  input wire req_valid_in,
  input wire [`PABC_AW-1:0] req_addr_in,
  input wire [1:0] req_byte_en_n_in,
  input wire req_write_in,
  input wire req_data_ctrl_in,
  input wire req_mem_io_in,
  input wire [`PABC_DW-1:0] req_wdata_in,
  output wire req_taken_out,
  output reg done_out,
  output reg [`PABC_DW-1:0] rd_data_out,
  output wire [2:0] bus_state_out
);
  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  wire [`PABC_SYNC_W-1:0] raw_in; // raw pins in one vector
  wire [`PABC_SYNC_W-1:0] flt_lvl; // filtered pin levels
  // reset levels of the filters, negated so no false edge follows reset
  localparam [`PABC_SYNC_W-1:0] in_rst_lvl = `PABC_IN_RST;
  assign raw_in = {hold_request_in, next_addr_request_n_in, ready_n_in};
  genvar gi;
  generate
    for (gi = 0; gi < `PABC_SYNC_W; gi = gi + 1) begin : g_sync
      reg s1_q; // first stage, read only by s2
      reg s2_q;
      reg s3_q;
      reg flt_q; // filtered level of this pin, one driver per bit
      assign flt_lvl[gi] = flt_q;
      // three flops; a change counts once stages two and three agree
      always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          s1_q <= in_rst_lvl[gi];
          s2_q <= in_rst_lvl[gi];
          s3_q <= in_rst_lvl[gi];
          flt_q <= in_rst_lvl[gi];
        end else begin
          s1_q <= raw_in[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            flt_q <= s3_q;
          end
        end
      end
    end
  endgenerate
  wire ready_act = ~flt_lvl[`PABC_IN_READY]; // ready seen asserted
  wire na_act = ~flt_lvl[`PABC_IN_NA]; // next address seen asserted
  wire hold_act = flt_lvl[`PABC_IN_HOLD]; // hold requested
  // ****************************************************************
  // state registers
  // ****************************************************************
  reg phase_q; // phase within the bus state
  reg [2:0] state_q; // current bus state
  reg [2:0] state_d;
  reg na_seen_q; // next address sampled in this cycle
  reg publish_d; // drive a new address at this boundary
  reg ack_d; // current cycle ends at this boundary
  reg cur_write_q; // current cycle is a write
  reg [`PABC_DW-1:0] cur_wdata_q; // write data of current cycle
  reg pub_write_q; // published, not yet started cycle is a write
  reg [`PABC_DW-1:0] pub_wdata_q;
  reg wr_hold_q; // write data hold through next phase one
  wire state_end = (phase_q == `PABC_PH_TWO); // boundary edge
  assign bus_state_out = state_q;
  // request taken exactly when its address goes to the pins
  assign req_taken_out = state_end & publish_d;
  // ****************************************************************
  // next bus state
  // ****************************************************************
  always @* begin
    state_d = state_q;
    publish_d = 1'b0;
    ack_d = 1'b0;
    case (state_q)
      `PABC_ST_IDLE: begin
        // idle starts nothing unless a request waits
        if (hold_act) begin
          state_d = `PABC_ST_HOLD;
        end else if (req_valid_in) begin
          state_d = `PABC_ST_NP1;
          publish_d = 1'b1;
        end
      end
      `PABC_ST_HOLD: begin
        // leaving hold always passes idle, so next cycle is plain
        if (!hold_act) begin
          state_d = `PABC_ST_IDLE;
        end
      end
      `PABC_ST_NP1: begin
        // ready ignored at the end of the first state
        state_d = `PABC_ST_NP2;
      end
      `PABC_ST_NP2: begin
        if (ready_act) begin
          ack_d = 1'b1;
          if (req_valid_in) begin
            state_d = `PABC_ST_NP1;
            publish_d = 1'b1;
          end else if (hold_act) begin
            state_d = `PABC_ST_HOLD;
          end else begin
            state_d = `PABC_ST_IDLE;
          end
        end else if (na_seen_q && req_valid_in) begin
          // wait state with request pending: publish early
          state_d = `PABC_ST_P2A;
          publish_d = 1'b1;
        end else if (na_seen_q) begin
          state_d = `PABC_ST_P2I;
        end
      end
      `PABC_ST_P1: begin
        // ready ignored here; never a one-state cycle
        if (!req_valid_in) begin
          state_d = `PABC_ST_P2I;
        end else if (na_seen_q) begin
          state_d = `PABC_ST_P2A;
          publish_d = 1'b1;
        end else begin
          state_d = `PABC_ST_NP2;
        end
      end
      `PABC_ST_P2A: begin
        // end here keeps pipelining; otherwise wait in place
        if (ready_act) begin
          ack_d = 1'b1;
          state_d = `PABC_ST_P1;
        end
      end
      `PABC_ST_P2I: begin
        if (ready_act) begin
          ack_d = 1'b1;
          if (req_valid_in) begin
            state_d = `PABC_ST_NP1;
            publish_d = 1'b1;
          end else if (hold_act) begin
            state_d = `PABC_ST_HOLD;
          end else begin
            state_d = `PABC_ST_IDLE;
          end
        end else if (req_valid_in) begin
          state_d = `PABC_ST_P2A;
          publish_d = 1'b1;
        end
      end
      default: begin
        state_d = `PABC_ST_IDLE;
      end
    endcase
  end
  // ****************************************************************
  // phase, state and next-address flag
  // ****************************************************************
  // phase toggles every edge, so a state spans two clock periods
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      phase_q <= `PABC_PH_ONE;
      state_q <= `PABC_ST_IDLE;
      na_seen_q <= 1'b0;
    end else begin
      phase_q <= ~phase_q;
      if (state_end) begin
        state_q <= state_d;
        if (ack_d || state_q == `PABC_ST_IDLE || state_q == `PABC_ST_HOLD) begin
          na_seen_q <= 1'b0;
        end
      end else if (state_q == `PABC_ST_NP2 || state_q == `PABC_ST_P1 ||
                   state_q == `PABC_ST_P2I) begin
        // sampled at the start of phase two; sticky, so repeats do nothing
        if (na_act) begin
          na_seen_q <= 1'b1;
        end
      end
    end
  end
  // ****************************************************************
  // address and cycle definition pins
  // ****************************************************************
  // pins change only when a request is published, so they stay valid
  // through every wait state until the following publish
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      addr_out <= {`PABC_AW{1'b0}};
      upper_byte_enable_n_out <= 1'b1;
      lower_byte_enable_n_out <= 1'b1;
      write_read_out <= 1'b0;
      data_ctrl_out <= 1'b0;
      mem_io_out <= 1'b0;
      addr_valid_strobe_n_out <= 1'b1;
      hold_grant_out <= 1'b0;
      pub_write_q <= 1'b0;
      pub_wdata_q <= {`PABC_DW{1'b0}};
    end else if (state_end) begin
      // strobe low in first plain state and in the next-addr state with a request (P2A), not P2I
      addr_valid_strobe_n_out <= ~(state_d == `PABC_ST_NP1 ||
                                   state_d == `PABC_ST_P2A);
      hold_grant_out <= (state_d == `PABC_ST_HOLD);
      if (publish_d) begin
        addr_out <= req_addr_in;
        upper_byte_enable_n_out <= req_byte_en_n_in[1];
        lower_byte_enable_n_out <= req_byte_en_n_in[0];
        write_read_out <= req_write_in;
        data_ctrl_out <= req_data_ctrl_in;
        mem_io_out <= req_mem_io_in;
        pub_write_q <= req_write_in;
        pub_wdata_q <= req_wdata_in;
      end
    end
  end
  // ****************************************************************
  // current cycle and data bus
  // ****************************************************************
  // the published cycle becomes current only when its first state
  // begins; a write may then still hold the old data for phase one
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cur_write_q <= 1'b0;
      cur_wdata_q <= {`PABC_DW{1'b0}};
      data_out <= {`PABC_DW{1'b0}};
      data_oe_out <= 1'b0;
      wr_hold_q <= 1'b0;
      done_out <= 1'b0;
      rd_data_out <= {`PABC_DW{1'b0}};
    end else begin
      done_out <= state_end & ack_d;
      if (state_end) begin
        if (state_d == `PABC_ST_NP1 && publish_d) begin
          cur_write_q <= req_write_in;
          cur_wdata_q <= req_wdata_in;
        end else if (state_d == `PABC_ST_P1) begin
          cur_write_q <= pub_write_q;
          cur_wdata_q <= pub_wdata_q;
        end
        if (ack_d) begin
          // read: pins latched on ready; write: hold for phase one
          if (!cur_write_q) begin
            rd_data_out <= data_in;
          end
          wr_hold_q <= cur_write_q;
        end
      end else begin
        // end of phase one: drop old write, start new one
        wr_hold_q <= 1'b0;
        if ((state_q == `PABC_ST_NP1 || state_q == `PABC_ST_P1) && cur_write_q) begin
          data_out <= cur_wdata_q;
          data_oe_out <= 1'b1;
        end else if (wr_hold_q) begin
          data_oe_out <= 1'b0;
        end else if (!cur_write_q) begin
          data_oe_out <= 1'b0;
        end
      end
    end
  end
endmodule // pabc_bus_cycles

/* tb/pabc_checker.sv */
`timescale 1ns/100ps
`include "pabc_bus_regs.vh"
module pabc_checker (
  // clock and reset
  input wire clk_sys_in,
  input wire reset_n_in,
  // watched outputs
  input wire [`PABC_AW-1:0] addr_out,
  input wire write_read_out,
  input wire addr_valid_strobe_n_out,
  input wire hold_grant_out,
  input wire [2:0] bus_state_out
);
  // ****************************************************************
  // bus state rules
  // ****************************************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  // short alias of the state code
  wire [2:0] st = bus_state_out;
  a_strobe_state: assert property ((st == `PABC_ST_NP1 || st == `PABC_ST_P2A) ==
    !addr_valid_strobe_n_out) else $error("strobe and state disagree");
  a_state_len: assert property ($changed(st) |=> $stable(st))
    else $error("bus state shorter than two clocks");
  a_pipe_entry: assert property ($changed(st) && st == `PABC_ST_P1 |->
    $past(st) == `PABC_ST_P2A) else $error("pipe first state without early address");
  a_pipe_first: assert property (st == `PABC_ST_P1 && $past(st) == `PABC_ST_P1 |=>
    st inside {`PABC_ST_P2A, `PABC_ST_P2I, `PABC_ST_NP2}) else $error("bad exit from pipe first");
  a_idle_plain: assert property ($past(st) inside {`PABC_ST_IDLE, `PABC_ST_HOLD} |->
    st inside {`PABC_ST_IDLE, `PABC_ST_HOLD, `PABC_ST_NP1}) else $error("pipelined after idle");
  a_hold_grant: assert property (hold_grant_out == (st == `PABC_ST_HOLD))
    else $error("hold grant out of hold state");
  a_wait_addr: assert property (st == `PABC_ST_P2A && $past(st) == `PABC_ST_P2A |->
    $stable(addr_out) && $stable(write_read_out)) else $error("early address moved");
  a_no_req_quiet: assert property ($past(st) == `PABC_ST_P1 && st == `PABC_ST_P2I |->
    addr_valid_strobe_n_out && $stable(addr_out)) else $error("address driven without request");
  a_wait_repeat: assert property (st == `PABC_ST_P2A && $past(st) == `PABC_ST_P2A |=>
    st inside {`PABC_ST_P2A, `PABC_ST_P1}) else $error("bad exit from next address state");
endmodule // pabc_checker
bind pabc_bus_cycles pabc_checker u_chk (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
  .addr_out(addr_out), .write_read_out(write_read_out), .hold_grant_out(hold_grant_out),
  .addr_valid_strobe_n_out(addr_valid_strobe_n_out), .bus_state_out(bus_state_out));

/* tb/pabc_sys_model.sv */
`timescale 1ns/100ps
module pabc_sys_model (
  // clock and reset
  input wire clk_sys_in,
  input wire reset_n_in,
  // controls from the bench
  input wire [7:0] wait_clks_in,
  input wire na_on_in,
  // bus watched
  input wire strobe_n_in,
  input wire done_in,
  // pins driven
  output wire ready_n_out,
  output wire na_n_out,
  output wire [15:0] data_out
);
  reg [7:0] cnt_q; // clocks since the current cycle began
  reg strobe_q; // last strobe level
  reg busy_q; // a cycle is in progress
  reg next_q; // the following cycle's address was strobed early
  reg [15:0] pat_q; // data word of the current cycle
  wire fall; // strobe has just gone low
  assign fall = strobe_q & ~strobe_n_in;
  // ack is a two-clock pulse: the pin filter needs two equal samples, and
  // a longer pulse would still be seen after the cycle has ended
  assign ready_n_out = !(busy_q && (cnt_q == wait_clks_in ||
                                    cnt_q == wait_clks_in + 8'h01));
  assign na_n_out = !na_on_in;
  assign data_out = pat_q;
  // a cycle starts at a strobe on a quiet bus, or at the end of the one
  // before it; a strobe inside a cycle only marks the next as pipelined
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_q <= 8'h00;
      strobe_q <= 1'b1;
      busy_q <= 1'b0;
      next_q <= 1'b0;
      pat_q <= 16'hC000;
    end else begin
      strobe_q <= strobe_n_in;
      if (done_in) begin
        cnt_q <= 8'h00;
        busy_q <= fall | next_q;
        next_q <= 1'b0;
        pat_q <= pat_q + 16'h0001; // next word per finished cycle
      end else begin
        if (fall && !busy_q) begin
          busy_q <= 1'b1;
          cnt_q <= 8'h00;
        end else if (cnt_q != 8'hFF) begin
          cnt_q <= cnt_q + 8'h01;
        end
        if (fall && busy_q) begin
          next_q <= 1'b1;
        end
      end
    end
  end
endmodule // pabc_sys_model

/* tb/pabc_bus_cycles_tb_top.sv */
`timescale 1ns/100ps
`include "pabc_bus_regs.vh"
module pabc_bus_cycles_tb_top;
  // ****************************************************************
  // stimulus, monitor and scenarios
  // ****************************************************************
  reg clk_sys_in = 1'b0;
  reg reset_n_in = 1'b0;
  reg hold = 1'b0;
  reg valid = 1'b0;
  reg [22:0] ra = 23'h0;
  reg rw = 1'b0;
  reg [15:0] wd = 16'h0;
  reg [7:0] wclk = 8'h00; // partner access time in clocks
  reg na_on = 1'b0;
  reg [1:0] be = 2'h2; // byte enables asked for: upper off, lower on
  reg [1:0] cdef = 2'h2; // cycle definition asked for: data, io
  reg clr_seen = 1'b0; // wipes the visited-state record
  wire rdy_n, na_n, stb_n, grant, wr, oe, taken, done;
  wire ube, lbe, dc, mio;
  wire [15:0] din, dout, rdata;
  wire [22:0] addr;
  wire [2:0] st;
  integer bad_count = 0;
  integer n_tests = 0;
  integer nd = 0; // finished cycles
  reg [7:0] seen = 8'h00; // states visited
  reg [15:0] got [0:15]; // read data per finished cycle
  always #2.5 clk_sys_in = ~clk_sys_in;
  pabc_bus_cycles dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .ready_n_in(rdy_n),
    .next_addr_request_n_in(na_n), .hold_request_in(hold), .data_in(din), .addr_out(addr),
    .upper_byte_enable_n_out(ube), .lower_byte_enable_n_out(lbe), .write_read_out(wr),
    .data_ctrl_out(dc), .mem_io_out(mio), .addr_valid_strobe_n_out(stb_n),
    .hold_grant_out(grant), .data_out(dout), .data_oe_out(oe), .req_valid_in(valid),
    .req_addr_in(ra), .req_byte_en_n_in(be), .req_write_in(rw),
    .req_data_ctrl_in(cdef[1]), .req_mem_io_in(cdef[0]),
    .req_wdata_in(wd), .req_taken_out(taken), .done_out(done), .rd_data_out(rdata),
    .bus_state_out(st));
  pabc_sys_model u_sys (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .wait_clks_in(wclk),
    .na_on_in(na_on), .strobe_n_in(stb_n), .done_in(done), .ready_n_out(rdy_n),
    .na_n_out(na_n), .data_out(din));
  // record states every clock, and read data as cycles finish
  always @(posedge clk_sys_in) begin
    seen <= clr_seen ? 8'h00 : (seen | (8'h01 << st));
    if (done === 1'b1) begin
      got[nd[3:0]] <= rdata;
      nd <= nd + 1;
    end
  end
  task cyc; begin
    @(posedge clk_sys_in);
    #1;
  end endtask
  task chk(input [22:0] e, input [22:0] g); begin
    n_tests = n_tests + 1;
    if (e !== g) begin
      bad_count = bad_count + 1;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  end endtask
  task stop_test; begin
    $display("compares %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  end endtask
  task hang; begin
    bad_count = bad_count + 1;
    $display("unexpected at %0t: wait ran out", $time);
    stop_test;
  end endtask
  // valid stays up so a following call can chain a new request
  task issue(input [22:0] a, input w, input [15:0] d);
    integer i;
    begin
      ra = a;
      rw = w;
      wd = d;
      valid = 1'b1;
      i = 0;
      // look at the combinational taken strobe mid-cycle, once settled
      @(negedge clk_sys_in);
      while (taken !== 1'b1) begin
        if (i > 200) hang;
        i = i + 1;
        @(negedge clk_sys_in);
      end
      cyc;
    end
  endtask
  task wait_nd(input integer n);
    integer i;
    begin
      for (i = 0; nd < n; i = i + 1) begin
        if (i > 400) hang;
        cyc;
      end
    end
  endtask
  task s_plain; begin
    issue(23'h000123, 1'b0, 16'h0);
    valid = 1'b0;
    wait_nd(1);
    chk(16'hC000, got[0]);
    chk(1'b0, seen[`PABC_ST_P1]);
    chk(23'h000123, addr);
    chk(2'h2, {ube, lbe});
    chk(2'h2, {dc, mio});
  end endtask
  task s_pipe; begin
    clr_seen = 1'b1;
    cyc;
    clr_seen = 1'b0;
    wclk = 8'h0E;
    na_on = 1'b1;
    issue(23'h000200, 1'b0, 16'h0);
    issue(23'h000202, 1'b0, 16'h0);
    issue(23'h000204, 1'b0, 16'h0);
    valid = 1'b0;
    wait_nd(4);
    chk(16'hC003, got[3]);
    chk(1'b1, seen[`PABC_ST_P2A]);
    chk(1'b1, seen[`PABC_ST_P1]);
    chk(1'b1, seen[`PABC_ST_P2I]);
  end endtask
  task s_write;
    integer i;
    begin
      issue(23'h000300, 1'b0, 16'h0);
      issue(23'h000302, 1'b1, 16'h3C5A);
      valid = 1'b0;
      for (i = 0; !(done === 1'b1 && nd == 5); i = i + 1) begin
        if (i > 200) hang;
        cyc;
      end
      chk(1'b1, oe);
      chk(1'b1, wr);
      chk(16'h3C5A, dout);
      chk(16'hC004, got[4]);
    end
  endtask
  task s_hold;
    integer i;
    begin
      // no early address here, so the plain cycle ends straight into hold
      na_on = 1'b0;
      hold = 1'b1;
      issue(23'h000400, 1'b0, 16'h0);
      valid = 1'b0;
      for (i = 0; grant !== 1'b1; i = i + 1) begin
        if (i > 200) hang;
        cyc;
      end
      chk(`PABC_ST_HOLD, st);
      hold = 1'b0;
      issue(23'h000402, 1'b0, 16'h0);
      valid = 1'b0;
      wait_nd(8);
      chk(16'hC007, got[7]);
    end
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_in);
    #1;
    reset_n_in = 1'b1;
    cyc;
    s_plain;
    s_pipe;
    s_write;
    s_hold;
    stop_test;
  end
endmodule // pabc_bus_cycles_tb_top
